// File: rtl/twi_regs.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "twi_map.svh"
module twi_regs
	import twi_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `TWI_STEP_NS / `TWI_CLK_NS
)(
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [`TWI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output wire logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output wire logic                   s_axi_wready,
	output wire logic [1:0]             s_axi_bresp,
	output wire logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`TWI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output wire logic                   s_axi_arready,
	output wire logic [31:0]            s_axi_rdata,
	output wire logic [1:0]             s_axi_rresp,
	output wire logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic [3:0]             timer_timeout,
	output wire logic [3:0]             timer_irq,
	output wire logic                   wdog_irq,
	output wire logic                   wdog_expire,
	output wire logic                   irq
);

	// Channel holding buffers and response registers; write address and data may come in any order.
	logic                   aw_full_q;
	logic [`TWI_ADDR_W-1:0] aw_addr_q;
	logic                   w_full_q;
	twi_word_t              w_data_q;
	logic [3:0]             w_strb_q;
	logic                   bvalid_q;
	twi_resp_t              bresp_q;
	logic                   rvalid_q;
	twi_word_t              rdata_q;
	twi_resp_t              rresp_q;

	// Register state.
	twi_count_t             load_q;
	twi_count_t             load_d;
	twi_count_t             thr_q;
	twi_count_t             thr_d;
	twi_count_t             cnt_q;
	twi_count_t             cnt_d;
	logic                   wst_q;
	logic                   wst_d;
	logic                   wmask_q;
	logic                   wmask_d;
	twi_tmask_t             tst_q;
	twi_tmask_t             tst_d;
	twi_tmask_t             ten_q;
	twi_tmask_t             ten_d;
	logic [31:0]            div_q;
	logic [31:0]            div_d;
	logic                   expire_q;

	// Write decode.
	wire                    wr_fire;
	wire [`TWI_ADDR_W-1:0]  wa;
	wire twi_word_t         bmask;
	wire twi_word_t         wd;
	wire twi_tmask_t        wd4;
	wire                    wd0;
	wire                    ws_kick;
	wire                    ws_load;
	wire                    ws_thr;
	wire                    ws_mask;
	wire                    ws_wstat;
	wire                    ws_wclr;
	wire                    ws_wset;
	wire                    ws_eclr;
	wire                    ws_eset;
	wire                    ws_tstat;
	wire                    ws_tclr;
	wire                    ws_tset;
	wire                    wr_hit;
	wire                    ro_hit;

	// Read decode.
	wire                    rd_fire;
	wire [`TWI_ADDR_W-1:0]  ra;
	wire                    rs_load;
	wire                    rs_thr;
	wire                    rs_cnt;
	wire                    rs_mask;
	wire                    rs_wstat;
	wire                    rs_tstat;
	wire                    rs_ten;
	wire                    rs_wo;
	wire                    rd_hit;
	wire twi_word_t         rd_word;

	// Watchdog and timer status.
	wire                    tick;
	wire                    kick;
	wire                    wd_run;
	wire twi_count_t        cnt_dec;
	wire                    thr_hit;
	wire                    cnt_end;
	wire                    wsw_set;
	wire                    wsw_clr;
	wire twi_tmask_t        tsw_set;
	wire twi_tmask_t        tsw_clr;

	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready  = !w_full_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// A write is performed only once both halves are held and the previous
	// response has gone, so at most one response is ever outstanding.
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign wa      = {aw_addr_q[`TWI_ADDR_W-1:2], 2'h0};
	assign bmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
	                  {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wd      = w_data_q & bmask;
	assign wd4     = wd[3:0];
	assign wd0     = wd[`TWI_WDOG_BIT];

	assign ws_kick  = wr_fire && (wa == `TWI_OFS_WATCHDOG_RELOAD_STROBE);
	assign ws_load  = wr_fire && (wa == `TWI_OFS_WDOG_LOAD);
	assign ws_thr   = wr_fire && (wa == `TWI_OFS_WDOG_THR);
	assign ws_mask  = wr_fire && (wa == `TWI_OFS_WDOG_MASK);
	assign ws_wstat = wr_fire && (wa == `TWI_OFS_WDOG_STAT);
	assign ws_wclr  = wr_fire && (wa == `TWI_OFS_WDOG_SCLR);
	assign ws_wset  = wr_fire && (wa == `TWI_OFS_WDOG_SSET);
	assign ws_eclr  = wr_fire && (wa == `TWI_OFS_TEN_CLR);
	assign ws_eset  = wr_fire && (wa == `TWI_OFS_TEN_SET);
	assign ws_tstat = wr_fire && (wa == `TWI_OFS_TSTAT);
	assign ws_tclr  = wr_fire && (wa == `TWI_OFS_TSCLR);
	assign ws_tset  = wr_fire && (wa == `TWI_OFS_TSSET);
	// The count and enable words are read-only; writes are quietly accepted.
	assign ro_hit   = (wa == `TWI_OFS_WDOG_CNT) || (wa == `TWI_OFS_TEN);
	assign wr_hit   = ws_kick || ws_load || ws_thr || ws_mask ||
	                  ws_wstat || ws_wclr || ws_wset || ws_eclr ||
	                  ws_eset || ws_tstat || ws_tclr || ws_tset ||
	                  (wr_fire && ro_hit);

	assign rd_fire  = s_axi_arvalid && !rvalid_q;
	assign ra       = {s_axi_araddr[`TWI_ADDR_W-1:2], 2'h0};
	assign rs_load  = (ra == `TWI_OFS_WDOG_LOAD);
	assign rs_thr   = (ra == `TWI_OFS_WDOG_THR);
	assign rs_cnt   = (ra == `TWI_OFS_WDOG_CNT);
	assign rs_mask  = (ra == `TWI_OFS_WDOG_MASK);
	assign rs_wstat = (ra == `TWI_OFS_WDOG_STAT);
	assign rs_tstat = (ra == `TWI_OFS_TSTAT);
	assign rs_ten   = (ra == `TWI_OFS_TEN);
	assign rs_wo    = (ra == `TWI_OFS_WATCHDOG_RELOAD_STROBE) ||
	                  (ra == `TWI_OFS_WDOG_SCLR) ||
	                  (ra == `TWI_OFS_WDOG_SSET) ||
	                  (ra == `TWI_OFS_TEN_CLR) ||
	                  (ra == `TWI_OFS_TEN_SET) ||
	                  (ra == `TWI_OFS_TSCLR) ||
	                  (ra == `TWI_OFS_TSSET);
	assign rd_hit   = rs_load || rs_thr || rs_cnt || rs_mask ||
	                  rs_wstat || rs_tstat || rs_ten || rs_wo;
	assign rd_word  = rs_load  ? {22'h0, load_q} :
	                  rs_thr   ? {22'h0, thr_q} :
	                  rs_cnt   ? {22'h0, cnt_q} :
	                  rs_mask  ? {31'h0, wmask_q} :
	                  rs_wstat ? {31'h0, wst_q} :
	                  rs_tstat ? {28'h0, tst_q} :
	                  rs_ten   ? {28'h0, ten_q} :
	                  32'h0;

	// Step divider; a kick restarts it so the first step after a reload
	// is always a full 21.5 ms.
	assign tick    = (div_q == TICK_CYCLES - 32'h1);
	assign div_d   = (tick || kick) ? 32'h0 : div_q + 32'h1;
	assign kick    = ws_kick && wd0;
	assign wd_run  = (load_q != `TWI_CNT_ZERO) &&
	                 (cnt_q != `TWI_CNT_ZERO);
	assign cnt_dec = cnt_q - `TWI_CNT_ONE;
	assign thr_hit = tick && wd_run && !kick &&
	                 (cnt_dec == thr_q);
	assign cnt_end = tick && wd_run && !kick &&
	                 (cnt_dec == `TWI_CNT_ZERO);
	assign cnt_d   = (load_q == `TWI_CNT_ZERO) ? `TWI_CNT_ZERO :
	                 kick ? load_q :
	                 (tick && wd_run) ? cnt_dec : cnt_q;

	assign load_d  = ws_load ? (load_q & ~bmask[9:0]) | wd[9:0] : load_q;
	assign thr_d   = ws_thr ? (thr_q & ~bmask[9:0]) | wd[9:0] : thr_q;
	assign wmask_d = ws_mask ? (wmask_q & ~bmask[0]) | wd0 : wmask_q;

	// Only the clear words clear; the status words stay read-only, so a
	// stray write there cannot lose an event. Hardware still wins a tie.
	assign wsw_set = ws_wset && wd0;
	assign wsw_clr = ws_wclr && wd0;
	assign wst_d   = thr_hit || wsw_set || (wst_q && !wsw_clr);

	assign tsw_set = ws_tset ? wd4 : 4'h0;
	assign tsw_clr = ws_tclr ? wd4 : 4'h0;

	genvar gi;
	generate
		for (gi = 0; gi < `TWI_NTIMER; gi++) begin : g_tmr
			assign tst_d[gi] = timer_timeout[gi] || tsw_set[gi] ||
			                   (tst_q[gi] && !tsw_clr[gi]);
			assign ten_d[gi] = (ws_eset && wd4[gi]) ||
			                   (ten_q[gi] &&
			                    !(ws_eclr && wd4[gi]));
			assign timer_irq[gi] = tst_q[gi] && ten_q[gi];
		end
	endgenerate

	assign wdog_irq    = wst_q && wmask_q;
	assign wdog_expire = expire_q;
	assign irq         = wdog_irq || (|timer_irq);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_full_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_full_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `TWI_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? `TWI_RESP_OKAY : `TWI_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= `TWI_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_hit ? `TWI_RESP_OKAY : `TWI_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_q   <= `TWI_CNT_ZERO;
			thr_q    <= `TWI_CNT_ZERO;
			cnt_q    <= `TWI_CNT_ZERO;
			wst_q    <= 1'b0;
			wmask_q  <= 1'b0;
			tst_q    <= 4'h0;
			ten_q    <= 4'h0;
			div_q    <= 32'h0;
			expire_q <= 1'b0;
		end else begin
			load_q   <= load_d;
			thr_q    <= thr_d;
			cnt_q    <= cnt_d;
			wst_q    <= wst_d;
			wmask_q  <= wmask_d;
			tst_q    <= tst_d;
			ten_q    <= ten_d;
			div_q    <= div_d;
			expire_q <= cnt_end;
		end
	end

	property p_thr_sets;
		@(posedge aclk) disable iff (!aresetn)
		(tick && wd_run && !kick && cnt_dec == thr_q) |=> wst_q;
	endproperty
	a_thr_sets: assert property (p_thr_sets)
		else $error("threshold reached but watchdog status not set");

	property p_cnt_read;
		@(posedge aclk) disable iff (!aresetn)
		(rd_fire && rs_cnt) |=>
			(rdata_q == {22'h0, $past(cnt_q)}) && rvalid_q;
	endproperty
	a_cnt_read: assert property (p_cnt_read)
		else $error("count readback wrong");

	property p_wst_read;
		@(posedge aclk) disable iff (!aresetn)
		(rd_fire && rs_wstat) |=> (rdata_q == {31'h0, $past(wst_q)});
	endproperty
	a_wst_read: assert property (p_wst_read)
		else $error("watchdog status readback wrong");

	property p_wst_clear;
		@(posedge aclk) disable iff (!aresetn)
		(ws_wclr && wd0 && !thr_hit && !wsw_set) |=> !wst_q;
	endproperty
	a_wst_clear: assert property (p_wst_clear)
		else $error("watchdog status not cleared");

	property p_wst_force;
		@(posedge aclk) disable iff (!aresetn)
		(ws_wset && wd0) |=> wst_q ##1 (wst_q || $past(wsw_clr));
	endproperty
	a_wst_force: assert property (p_wst_force)
		else $error("watchdog status not forced");

	property p_en_clear;
		@(posedge aclk) disable iff (!aresetn)
		ws_eclr |=> ten_q == ($past(ten_q) & ~$past(wd4));
	endproperty
	a_en_clear: assert property (p_en_clear)
		else $error("enable clear wrong");

	property p_en_set;
		@(posedge aclk) disable iff (!aresetn)
		ws_eset |=> ten_q == ($past(ten_q) | $past(wd4));
	endproperty
	a_en_set: assert property (p_en_set)
		else $error("enable set wrong");

	property p_en_stable;
		@(posedge aclk) disable iff (!aresetn)
		!(ws_eclr || ws_eset) |=> $stable(ten_q);
	endproperty
	a_en_stable: assert property (p_en_stable)
		else $error("enable changed without set or clear");

	property p_event_wins;
		@(posedge aclk) disable iff (!aresetn)
		(timer_timeout != 4'h0) |=>
			((tst_q & $past(timer_timeout)) == $past(timer_timeout));
	endproperty
	a_event_wins: assert property (p_event_wins)
		else $error("timeout event lost");

	property p_tst_clear;
		@(posedge aclk) disable iff (!aresetn)
		(ws_tclr && timer_timeout == 4'h0) |=> ((tst_q & $past(wd4)) == 4'h0);
	endproperty
	a_tst_clear: assert property (p_tst_clear)
		else $error("timer status not cleared");

	property p_tst_set;
		@(posedge aclk) disable iff (!aresetn)
		ws_tset |=> ((tst_q & $past(wd4)) == $past(wd4));
	endproperty
	a_tst_set: assert property (p_tst_set)
		else $error("timer status not set");

	property p_kick_load;
		@(posedge aclk) disable iff (!aresetn)
		kick |=> (cnt_q == $past(load_q));
	endproperty
	a_kick_load: assert property (p_kick_load)
		else $error("kick did not reload count");

	property p_disabled;
		@(posedge aclk) disable iff (!aresetn)
		(load_q == `TWI_CNT_ZERO) [*2] |-> (cnt_q == `TWI_CNT_ZERO) && !thr_hit;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("watchdog runs while disabled");

	property p_timer_irq;
		@(posedge aclk) disable iff (!aresetn)
		(timer_timeout[0] && ten_q[0] && !(ws_eclr && wd4[0])) |=>
			timer_irq[0] && irq;
	endproperty
	a_timer_irq: assert property (p_timer_irq)
		else $error("timer request not raised");

endmodule : twi_regs

// File: rtl/twi_map.svh
`ifndef TWI_MAP_SVH
`define TWI_MAP_SVH
`define TWI_ADDR_W        14
`define TWI_NTIMER        4
`define TWI_CNT_W         10
`define TWI_OFS_WATCHDOG_RELOAD_STROBE 14'h0030
`define TWI_OFS_WDOG_LOAD 14'h0034
`define TWI_OFS_WDOG_THR  14'h0038
`define TWI_OFS_WDOG_CNT  14'h003C
`define TWI_OFS_WDOG_MASK 14'h0040
`define TWI_OFS_WDOG_STAT 14'h3FCC
`define TWI_OFS_WDOG_SCLR 14'h3FD0
`define TWI_OFS_WDOG_SSET 14'h3FD4
`define TWI_OFS_TEN_CLR   14'h3FD8
`define TWI_OFS_TEN_SET   14'h3FDC
`define TWI_OFS_TSTAT     14'h3FE0
`define TWI_OFS_TEN       14'h3FE4
`define TWI_OFS_TSCLR     14'h3FE8
`define TWI_OFS_TSSET     14'h3FEC
`define TWI_WDOG_BIT      0
`define TWI_CNT_ZERO      10'h000
`define TWI_CNT_ONE       10'h001
`define TWI_RESP_OKAY     2'h0
`define TWI_RESP_SLVERR   2'h2
`define TWI_STEP_NS       21500000
`define TWI_CLK_NS        8
`endif

// File: rtl/twi_pkg.sv
package twi_pkg;
	typedef logic [9:0]  twi_count_t;
	typedef logic [3:0]  twi_tmask_t;
	typedef logic [1:0]  twi_resp_t;
	typedef logic [31:0] twi_word_t;
endpackage : twi_pkg

// File: tb/twi_regs_test.sv
`timescale 1ns/1ps
`include "twi_map.svh"
`define CHK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("Error %0t: got %h expected %h", $time, got, exp); \
	end \
end
module twi_regs_test;
	import twi_pkg::*;
	typedef struct packed {
		logic [13:0] wa;
		twi_word_t   wd;
		logic [3:0]  ws;
		logic [13:0] ra;
		twi_word_t   rd;
		logic [4:0]  irqs;
	} twi_row_t;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic [13:0] awaddr;
	logic        awvalid;
	logic        awready;
	twi_word_t   wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	twi_resp_t   bresp;
	logic        bvalid;
	logic        bready;
	logic [13:0] araddr;
	logic        arvalid;
	logic        arready;
	twi_word_t   rdata;
	twi_resp_t   rresp;
	logic        rvalid;
	logic        rready;
	twi_tmask_t  timer_timeout;
	twi_tmask_t  timer_irq;
	logic        wdog_irq;
	logic        wdog_expire;
	logic        irq;
	int          fails = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          n;
	// Each row writes one word, then reads one back with the irq outputs.
	twi_row_t    rows [17] = '{
		'{`TWI_OFS_TEN_SET, 32'h5, 4'hF, `TWI_OFS_TEN, 32'h5, 5'h00},
		'{`TWI_OFS_TEN_SET, 32'hF, 4'h0, `TWI_OFS_TEN, 32'h5, 5'h00},
		'{`TWI_OFS_TEN_SET, 32'hA, 4'hF, `TWI_OFS_TEN, 32'hF, 5'h00},
		'{`TWI_OFS_TEN_CLR, 32'h6, 4'hF, `TWI_OFS_TEN, 32'h9, 5'h00},
		'{`TWI_OFS_TEN, 32'hF, 4'hF, `TWI_OFS_TEN, 32'h9, 5'h00},
		'{`TWI_OFS_TSSET, 32'h3, 4'hF, `TWI_OFS_TSTAT, 32'h3, 5'h11},
		'{`TWI_OFS_TSSET, 32'hC, 4'hF, `TWI_OFS_TSTAT, 32'hF, 5'h19},
		'{`TWI_OFS_TSCLR, 32'h5, 4'hF, `TWI_OFS_TSTAT, 32'hA, 5'h18},
		'{`TWI_OFS_TSTAT, 32'hF, 4'hF, `TWI_OFS_TSTAT, 32'hA, 5'h18},
		'{`TWI_OFS_WDOG_SSET, 32'h1, 4'hF, `TWI_OFS_WDOG_STAT, 32'h1, 5'h18},
		'{`TWI_OFS_WDOG_STAT, 32'h1, 4'hF, `TWI_OFS_WDOG_STAT, 32'h1, 5'h18},
		'{`TWI_OFS_WDOG_SCLR, 32'h0, 4'hF, `TWI_OFS_WDOG_STAT, 32'h1, 5'h18},
		'{`TWI_OFS_WDOG_SCLR, 32'h1, 4'hF, `TWI_OFS_WDOG_STAT, 32'h0, 5'h18},
		'{`TWI_OFS_WDOG_SSET, 32'h0, 4'hF, `TWI_OFS_WDOG_STAT, 32'h0, 5'h18},
		'{`TWI_OFS_WDOG_THR, 32'hFFFFFFFF, 4'hF, `TWI_OFS_WDOG_THR, 32'h3FF,
			5'h18},
		'{`TWI_OFS_WDOG_CNT, 32'h55, 4'hF, `TWI_OFS_WDOG_CNT, 32'h0, 5'h18},
		'{`TWI_OFS_TSCLR, 32'h0, 4'hF, `TWI_OFS_TSSET, 32'h0, 5'h18}
	};
	logic [13:0] zero_regs [7] = '{`TWI_OFS_WDOG_THR, `TWI_OFS_WDOG_CNT,
		`TWI_OFS_WDOG_STAT, `TWI_OFS_TSTAT, `TWI_OFS_TEN, `TWI_OFS_WDOG_LOAD,
		`TWI_OFS_WDOG_MASK};

	always #4 aclk = ~aclk;

	// A small tick keeps the watchdog scenarios to a few dozen cycles.
	twi_regs #(
		.TICK_CYCLES(4)
	) DUT (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.timer_timeout(timer_timeout),
		.timer_irq(timer_irq),
		.wdog_irq(wdog_irq),
		.wdog_expire(wdog_expire),
		.irq(irq)
	);

	task automatic close_out;
		if (fails == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	// Ready is looked at on the falling edge, so the handshake edge is known.
	task automatic wchk(input logic [13:0] a, input twi_word_t d,
			input logic [3:0] s, input twi_resp_t er = `TWI_RESP_OKAY);
		logic a_hit;
		logic d_hit;
		logic b_hit;
		twi_resp_t r;
		a_hit = 1'b0;
		d_hit = 1'b0;
		b_hit = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a_hit && d_hit)) begin
			@(negedge aclk);
			a_hit = a_hit || awready;
			d_hit = d_hit || wready;
			@(posedge aclk);
			if (a_hit) awvalid <= 1'b0;
			if (d_hit) wvalid <= 1'b0;
		end
		while (!b_hit) begin
			@(negedge aclk);
			b_hit = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		`CHK(r, er)
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wchk

	task automatic rchk(input logic [13:0] a, input twi_word_t ed,
			input twi_resp_t er = `TWI_RESP_OKAY);
		logic hit;
		twi_word_t d;
		twi_resp_t r;
		hit = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!hit) begin
			@(negedge aclk);
			hit = arready;
			@(posedge aclk);
			if (hit) arvalid <= 1'b0;
		end
		hit = 1'b0;
		while (!hit) begin
			@(negedge aclk);
			hit = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
		`CHK({r, d}, {er, ed})
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rchk

	task automatic irq_chk(input logic [5:0] e);
		@(negedge aclk);
		`CHK({wdog_irq, irq, timer_irq}, e)
		@(posedge aclk);
	endtask : irq_chk

	// The ceiling is more than ten times what the whole sequence needs.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fails++;
			close_out();
		end
	end

	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
		{araddr, arvalid, rready, timer_timeout} <= '0;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (rows[i]) begin
			wchk(rows[i].wa, rows[i].wd, rows[i].ws);
			rchk(rows[i].ra, rows[i].rd);
			irq_chk({1'b0, rows[i].irqs});
		end
		// Timer 0 fires on every cycle of a clear that hits all four bits.
		timer_timeout <= 4'h1;
		wchk(`TWI_OFS_TSCLR, 32'hF, 4'hF);
		timer_timeout <= 4'h0;
		rchk(`TWI_OFS_TSTAT, 32'h1);
		timer_timeout <= 4'hA;
		@(posedge aclk);
		timer_timeout <= 4'h0;
		rchk(`TWI_OFS_TSTAT, 32'hB);
		irq_chk(6'h19);
		wchk(14'h0100, 32'h1, 4'hF, `TWI_RESP_SLVERR);
		rchk(14'h0100, 32'h0, `TWI_RESP_SLVERR);
		wchk(`TWI_OFS_WDOG_THR, 32'h3, 4'hF);
		wchk(`TWI_OFS_WDOG_LOAD, 32'h5, 4'hF);
		wchk(`TWI_OFS_WDOG_MASK, 32'h1, 4'hF);
		wchk(`TWI_OFS_WATCHDOG_RELOAD_STROBE, 32'h1, 4'hF);
		rchk(`TWI_OFS_WDOG_CNT, 32'h5);
		n = 0;
		while (!wdog_irq && n < 40) begin
			@(negedge aclk);
			n++;
		end
		`CHK(wdog_irq, 1'b1)
		@(posedge aclk);
		rchk(`TWI_OFS_WDOG_STAT, 32'h1);
		n = 0;
		while (!wdog_expire && n < 40) begin
			@(negedge aclk);
			n++;
		end
		`CHK(wdog_expire, 1'b1)
		@(posedge aclk);
		rchk(`TWI_OFS_WDOG_CNT, 32'h0);
		wchk(`TWI_OFS_WDOG_SCLR, 32'h1, 4'hF);
		irq_chk(6'h19);
		wchk(`TWI_OFS_WATCHDOG_RELOAD_STROBE, 32'h1, 4'hF);
		wchk(`TWI_OFS_WDOG_LOAD, 32'h0, 4'hF);
		rchk(`TWI_OFS_WDOG_CNT, 32'h0);
		// A second reset in mid-run must bring every field back to zero.
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (zero_regs[i]) begin
			rchk(zero_regs[i], 32'h0);
		end
		irq_chk(6'h00);
		close_out();
	end
endmodule : twi_regs_test
